// [rxcal_control.sv]
/*
 * Receive calibration and reset control register bank.
 * Holds the calibration control register, a reference enable register and
 * a status register behind an Avalon-MM slave with waitrequest, starts the
 * internal receive calibrations, picks the VCO calibration strategy for
 * lock acquisition and runs a timed receive-side soft reset.
 * Assumes the calibration engines, the clock data recovery loop and the
 * reference detector sit outside on their own timing; their levels are
 * synchronised here. Other receive registers follow rx_soft_reset_o.
 */
// The Avalon-MM slave port was left to the implementer.
// Behaviour
// [RL1] Writing one to force_recalibration starts every receive calibration.
// [RL2] A recalibration leaves all receive-side register contents alone.
// [RL3] force_recalibration clears itself once every calibration is done.
// [RL4] vco_calibration_mode resets to automatic, which centres on a present and enabled reference.
// [RL5] In automatic mode without a present or enabled reference the full VCO range is swept.
// [RL6] Referenceless mode always sweeps the full VCO range.
// [RL7] Reference mode always centres the VCO pull range on the reference.
// [RL8] The invalid mode keeps loss_of_lock asserted for as long as it is set.
// [RL9] The host uses reference or automatic mode whenever it sets loopback.
// [RL10] The host leaves registers 77 and 98 alone while the reference is centring the VCO.
// [RL11] Writing one to receive_soft_reset returns every receive register to reset.
// [RL12] receive_soft_reset clears itself when the register reset has ended.
// [RL13] receiver_reference_enable decides whether automatic mode may use the reference.
// [RL14] Writing zero to a self-clearing bit does nothing; a running action finishes.
// [RL15] The upper four bits of the calibration control register read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module rxcal_control
	import rxcal_pkg::*;
(
	input  wire logic                            clk_sys_i,
	input  wire logic                            rst_b_i,
	// Avalon-MM slave
	input  wire logic [rxcal_pkg::ADDR_W-1:0]    avs_address_i,
	input  wire logic                            avs_read_i,
	input  wire logic                            avs_write_i,
	input  wire logic [rxcal_pkg::DATA_W-1:0]    avs_writedata_i,
	input  wire logic [rxcal_pkg::BE_W-1:0]      avs_byteenable_i,
	output logic      [rxcal_pkg::DATA_W-1:0]    avs_readdata_o,
	output logic      [1:0]                      avs_response_o,
	output logic                                 avs_waitrequest_o,
	// Reference clock detector and lock detector levels
	input  wire logic                            ref_clock_present_i,
	input  wire logic                            cdr_loss_of_lock_i,
	// Calibration engines
	input  wire logic [rxcal_pkg::CAL_COUNT-1:0] cal_done_i,
	output logic      [rxcal_pkg::CAL_COUNT-1:0] cal_start_o,
	// Lock acquisition strategy, loss of lock alarm and soft reset
	output logic                                 vco_centre_on_ref_o,
	output logic                                 vco_full_sweep_o,
	output logic                                 loss_of_lock_o,
	output logic                                 rx_soft_reset_o
);

	import rxcal_pkg::*;

	// Synchronised inputs
	logic [CAL_COUNT+1:0] sync_in;
	logic [CAL_COUNT+1:0] sync_out;
	logic                 ref_present;
	logic                 cdr_lol;
	logic [CAL_COUNT-1:0] cal_done;

	// Pin levels pass two flip-flops before use
	assign sync_in = {cal_done_i, cdr_loss_of_lock_i, ref_clock_present_i};

	rxcal_sync #(
		.W (CAL_COUNT + 2)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.async_i   (sync_in),
		.sync_o    (sync_out)
	);

	assign ref_present = sync_out[0];
	assign cdr_lol     = sync_out[1];
	assign cal_done    = sync_out[CAL_COUNT+1:2];

	// Bus handshake: one wait cycle, answer on the second cycle
	logic                ack_q;
	logic                req;
	logic                first_cycle;
	logic                wr_take;
	logic                lane0;
	logic                hit_cal_ctrl;
	logic                hit_ref_ctrl;
	logic                hit_cal_stat;
	logic                hit_any;
	logic [DATA_W-1:0]   rdata_d;
	logic [DATA_W-1:0]   rdata_q;
	logic [1:0]          resp_d;
	logic [1:0]          resp_q;

	// Request decode
	assign req          = avs_read_i | avs_write_i;
	assign first_cycle  = req & ~ack_q;
	assign wr_take      = avs_write_i & ack_q;
	assign lane0        = avs_byteenable_i[0];
	assign hit_cal_ctrl = (avs_address_i == ADDR_CAL_CTRL);
	assign hit_ref_ctrl = (avs_address_i == ADDR_REF_CTRL);
	assign hit_cal_stat = (avs_address_i == ADDR_CAL_STAT);
	assign hit_any      = hit_cal_ctrl | hit_ref_ctrl | hit_cal_stat;

	// Wait is released in the cycle after the request appears
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= first_cycle;
		end
	end

	assign avs_waitrequest_o = first_cycle;

	// Register state
	rxcal_vco_mode_t  vco_mode_q;
	rxcal_vco_mode_t  vco_mode_d;
	logic             ref_en_q;
	logic             ref_en_d;
	rxcal_rst_state_t rst_state_q;
	rxcal_rst_state_t rst_state_d;
	logic [RST_CNT_W-1:0] rst_cnt_q;
	logic [RST_CNT_W-1:0] rst_cnt_d;
	logic             wr_cal_ctrl;
	logic             wr_ref_ctrl;
	logic             recal_req;
	logic             reset_req;
	logic             reset_busy;
	logic             reset_end;
	logic             cal_busy;

	// Write strobes on the edge where waitrequest is low
	assign wr_cal_ctrl = wr_take & hit_cal_ctrl & lane0;
	assign wr_ref_ctrl = wr_take & hit_ref_ctrl & lane0;

	// Only a written one starts an action, and not while it runs
	assign recal_req = wr_cal_ctrl & avs_writedata_i[BIT_FORCE_RECAL]
		& ~cal_busy; // RL14
	assign reset_req = wr_cal_ctrl & avs_writedata_i[BIT_SOFT_RESET]
		& ~reset_busy; // RL14

	// Soft reset sequencer
	localparam logic [RST_CNT_W-1:0] RST_LAST =
		RST_CNT_W'(SOFT_RESET_CYC - 1);

	assign reset_busy = (rst_state_q == RST_RUN);
	assign reset_end  = reset_busy & (rst_cnt_q == RST_LAST);

	// Next state of the reset timer
	always_comb begin
		rst_state_d = rst_state_q;
		rst_cnt_d   = rst_cnt_q;
		case (rst_state_q)
			RST_IDLE: begin
				rst_cnt_d = '0;
				if (reset_req) begin
					rst_state_d = RST_RUN; // RL11
				end
			end
			RST_RUN: begin
				rst_cnt_d = rst_cnt_q + 1'b1;
				if (reset_end) begin
					rst_state_d = RST_IDLE; // RL12
					rst_cnt_d   = '0;
				end
			end
			default: begin
				rst_state_d = RST_IDLE;
				rst_cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			rst_state_q <= RST_IDLE;
			rst_cnt_q   <= '0;
		end else begin
			rst_state_q <= rst_state_d;
			rst_cnt_q   <= rst_cnt_d;
		end
	end

	// Receive-side configuration registers
	// Soft reset holds them at reset values; recalibration never touches
	// them, so settings survive a recalibration
	always_comb begin
		vco_mode_d = vco_mode_q;
		ref_en_d   = ref_en_q;
		if (reset_busy) begin
			vco_mode_d = VCO_MODE_RST; // RL11
			ref_en_d   = REF_EN_RST; // RL11
		end else begin
			if (wr_cal_ctrl) begin
				vco_mode_d = rxcal_vco_mode_t'(
					avs_writedata_i[BIT_VCO_MSB:BIT_VCO_LSB]);
			end
			if (wr_ref_ctrl) begin
				ref_en_d = avs_writedata_i[BIT_REF_EN];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			vco_mode_q <= VCO_MODE_RST; // RL4
			ref_en_q   <= REF_EN_RST;
		end else begin
			vco_mode_q <= vco_mode_d; // RL2
			ref_en_q   <= ref_en_d;
		end
	end

	// Calibration launch and tracking
	rxcal_sequencer u_seq (
		.clk_sys_i   (clk_sys_i),
		.rst_b_i     (rst_b_i),
		.start_i     (recal_req), // RL1
		.done_i      (cal_done),
		.cal_start_o (cal_start_o),
		.busy_o      (cal_busy)
	);

	// VCO calibration strategy
	logic ref_usable;
	logic centre_d;
	logic sweep_d;
	logic lol_d;
	logic centre_q;
	logic sweep_q;
	logic lol_q;

	// Automatic mode uses the reference only when present and enabled
	assign ref_usable = ref_present & ref_en_q; // RL13

	always_comb begin
		centre_d = 1'b0;
		sweep_d  = 1'b0;
		case (vco_mode_q)
			VCO_AUTO: begin
				centre_d = ref_usable; // RL4
				sweep_d  = ~ref_usable; // RL5
			end
			VCO_REFLESS: begin
				sweep_d = 1'b1; // RL6
			end
			VCO_REF: begin
				centre_d = 1'b1; // RL7
			end
			default: begin
				centre_d = 1'b0;
				sweep_d  = 1'b0;
			end
		endcase
	end

	// Invalid mode pins the loss of lock alarm on
	assign lol_d = cdr_lol | (vco_mode_q == VCO_INVALID); // RL8

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			centre_q <= 1'b0;
			sweep_q  <= 1'b0;
			lol_q    <= 1'b0;
		end else begin
			centre_q <= centre_d;
			sweep_q  <= sweep_d;
			lol_q    <= lol_d;
		end
	end

	assign vco_centre_on_ref_o = centre_q;
	assign vco_full_sweep_o    = sweep_q;
	assign loss_of_lock_o      = lol_q;
	assign rx_soft_reset_o     = reset_busy;

	// Read data and response
	logic [7:0] cal_ctrl_rd;
	logic [7:0] ref_ctrl_rd;
	logic [7:0] cal_stat_rd;

	// Upper bits read zero; self-clearing bits show the running action
	assign cal_ctrl_rd = {4'h0, cal_busy, vco_mode_q, reset_busy}; // RL15
	assign ref_ctrl_rd = {7'h00, ref_en_q};
	assign cal_stat_rd = {2'b00, reset_busy, cal_busy, sweep_q, centre_q,
		ref_present, lol_q};

	always_comb begin
		rdata_d = '0;
		if (hit_cal_ctrl) begin
			rdata_d = {24'h000000, cal_ctrl_rd}; // RL3
		end else if (hit_ref_ctrl) begin
			rdata_d = {24'h000000, ref_ctrl_rd};
		end else if (hit_cal_stat) begin
			rdata_d = {24'h000000, cal_stat_rd};
		end
	end

	assign resp_d = hit_any ? RESP_OKAY : RESP_SLVERR;

	// Captured in the wait cycle so they stand at the answering edge
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
			resp_q  <= RESP_OKAY;
		end else if (first_cycle) begin
			rdata_q <= avs_read_i ? rdata_d : '0;
			resp_q  <= resp_d;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_response_o = resp_q;

endmodule

`default_nettype wire

// [rxcal_control_sva.sv]
/* Port checker for the receive calibration and reset control block.
   Assumes it is bound to every rxcal_control and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module rxcal_control_sva
	import rxcal_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic [1:0]  avs_response_o,
	input wire logic        avs_waitrequest_o,
	input wire logic [3:0]  cal_start_o,
	input wire logic        vco_centre_on_ref_o,
	input wire logic        vco_full_sweep_o,
	input wire logic        loss_of_lock_o,
	input wire logic        rx_soft_reset_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	logic [4:0] run_q;
	// Accepted transfers and what they ask for
	wire ack = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	wire cal_wr = ack & avs_write_i & (avs_address_i == ADDR_CAL_CTRL);
	wire mapped = avs_address_i inside {ADDR_CAL_CTRL, ADDR_REF_CTRL,
		ADDR_CAL_STAT};
	// Cycles the soft reset has been running
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || !rx_soft_reset_o)
			run_q <= 5'h00;
		else
			run_q <= run_q + 5'h01;
	end
	sequence s_pulse; cal_start_o == 4'hf ##1 cal_start_o == 4'h0; endsequence
	property p_start; cal_start_o != 4'h0 |-> s_pulse; endproperty
	a_start: assert property (p_start) else $error("start not one wide pulse");
	property p_cause; cal_start_o != 4'h0 |-> $past(cal_wr && avs_writedata_i[3]); endproperty
	a_cause: assert property (p_cause) else $error("start without write");
	property p_excl; !(vco_centre_on_ref_o && vco_full_sweep_o); endproperty
	a_excl: assert property (p_excl) else $error("centre and sweep");
	property p_invalid; !vco_centre_on_ref_o && !vco_full_sweep_o
		&& $past(rst_b_i) |-> loss_of_lock_o; endproperty
	a_invalid: assert property (p_invalid) else $error("lock alarm low");
	property p_upper; ack && avs_read_i |-> avs_readdata_o[31:8] == 24'h0
		&& (avs_address_i != ADDR_CAL_CTRL || avs_readdata_o[7:4] == 4'h0); endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_resp; ack |-> avs_response_o == (mapped ? RESP_OKAY : RESP_SLVERR); endproperty
	a_resp: assert property (p_resp) else $error("bad response");
	property p_srst_len; $fell(rx_soft_reset_o) |-> run_q == SOFT_RESET_CYC; endproperty
	a_srst_len: assert property (p_srst_len) else $error("soft reset length");
	property p_srst_cause; $rose(rx_soft_reset_o) |-> $past(cal_wr && avs_writedata_i[0]); endproperty
	a_srst_cause: assert property (p_srst_cause) else $error("reset without write");
	// Forced mode reaches the strategy flops two cycles into the reset
	property p_srst_mode; rx_soft_reset_o && $past(rx_soft_reset_o, 2)
		|-> vco_full_sweep_o; endproperty
	a_srst_mode: assert property (p_srst_mode) else $error("mode not reset");
endmodule
bind rxcal_control rxcal_control_sva u_sva (.*);
`default_nettype wire

// [rxcal_control_tb.sv]
/* Self-checking bench for rxcal_control with the engine model.
   Assumes a 100 MHz clock and one Avalon-MM master driven here. */
`timescale 1ns/1ps
`default_nettype none
module rxcal_control_tb;
	import rxcal_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_b_i   = 1'b0;
	logic [7:0]  adr       = 8'h00;
	logic        rd        = 1'b0;
	logic        wr        = 1'b0;
	logic [31:0] wd        = 32'h0;
	logic [3:0]  be        = 4'h0;
	logic        refp      = 1'b0;
	logic        cdrl      = 1'b0;
	logic [31:0] rdata;
	logic [1:0]  resp;
	logic        wreq;
	logic [3:0]  done;
	logic [3:0]  start;
	logic        centre;
	logic        sweep;
	logic        loss_of_lock;
	logic        srst;
	logic [31:0] got_d;
	logic [1:0]  got_r;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          n_start = 0;
	rxcal_control dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_response_o(resp), .avs_waitrequest_o(wreq),
		.ref_clock_present_i(refp), .cdr_loss_of_lock_i(cdrl),
		.cal_done_i(done), .cal_start_o(start),
		.vco_centre_on_ref_o(centre), .vco_full_sweep_o(sweep),
		.loss_of_lock_o(loss_of_lock), .rx_soft_reset_o(srst));
	rxcal_engines eng (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.start_i(start), .done_o(done));
	// Clock and start pulse counter
	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (start == 4'hf) n_start++;
	task automatic tally_and_finish;
		$display("Checked %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One transfer, held until waitrequest is sampled low at a rising edge
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] b);
		int k;
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		be <= b;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (wreq !== 1'b0 && k < 20);
		if (wreq !== 1'b0) begin
			chk("waitrequest", 32'h0, 32'(wreq));
			tally_and_finish();
		end
		got_d = rdata;
		got_r = resp;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic wrr(logic [7:0] a, logic [31:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task automatic rdc(string what, logic [7:0] a, logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'h1);
		chk(what, exp, got_d);
	endtask
	// Reads until the masked bits of the control register clear
	task automatic poll(logic [31:0] mask);
		int k;
		k = 0;
		do begin
			bus(1'b0, ADDR_CAL_CTRL, 32'h0, 4'h1);
			k++;
		end while ((got_d & mask) != 0 && k < 50);
		if ((got_d & mask) !== 32'h0) begin
			chk("poll", 32'h0, got_d & mask);
			tally_and_finish();
		end
	endtask
	task automatic t_reset;
		rdc("cal ctrl", ADDR_CAL_CTRL, 32'h0);
		rdc("ref ctrl", ADDR_REF_CTRL, 32'h0);
		chk("sweep", 1, sweep);
		$display("test reset done");
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			for (int p = 0; p < 2; p++) begin
				for (int e = 0; e < 2; e++) begin
					refp <= p[0];
					wrr(ADDR_REF_CTRL, 32'(e));
					wrr(ADDR_CAL_CTRL, 32'hf0 | 32'(m << 1));
					repeat (4) @(posedge clk_sys_i);
					chk("centre", m == 2 || (m == 0 && p && e), centre);
					chk("sweep", m == 1 || (m == 0 && !(p && e)), sweep);
					chk("lol", m == 3, loss_of_lock);
					rdc("mode", ADDR_CAL_CTRL, 32'(m << 1));
				end
			end
		end
		wrr(ADDR_CAL_CTRL, 32'h0);
		cdrl <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk("lol input", 1, loss_of_lock);
		rdc("status", ADDR_CAL_STAT, 32'h07);
		cdrl <= 1'b0;
		$display("test modes done");
	endtask
	task automatic t_recal;
		refp <= 1'b1;
		wrr(ADDR_REF_CTRL, 32'h1);
		wrr(ADDR_CAL_CTRL, 32'h04);
		wrr(ADDR_CAL_CTRL, 32'h0c);
		rdc("recal busy", ADDR_CAL_CTRL, 32'h0c);
		wrr(ADDR_CAL_CTRL, 32'h04);
		rdc("recal kept", ADDR_CAL_CTRL, 32'h0c);
		poll(32'h08);
		chk("recal end", 32'h04, got_d);
		rdc("ref kept", ADDR_REF_CTRL, 32'h1);
		chk("starts", 1, n_start);
		chk("engines", 4'hf, done);
		$display("test recal done");
	endtask
	task automatic t_srst;
		wrr(ADDR_CAL_CTRL, 32'h02);
		wrr(ADDR_CAL_CTRL, 32'h05);
		rdc("srst busy", ADDR_CAL_CTRL, 32'h01);
		chk("srst pin", 1, srst);
		poll(32'h01);
		chk("srst end", 32'h0, got_d);
		rdc("ref cleared", ADDR_REF_CTRL, 32'h0);
		chk("srst pin end", 0, srst);
		$display("test soft reset done");
	endtask
	task automatic t_bus;
		bus(1'b0, 8'h04, 32'h0, 4'h1);
		chk("unmapped resp", RESP_SLVERR, got_r);
		chk("unmapped data", 32'h0, got_d);
		bus(1'b1, ADDR_CAL_CTRL, 32'h04, 4'h0);
		rdc("byte off", ADDR_CAL_CTRL, 32'h0);
		$display("test bus done");
	endtask
	// Reset, then every scenario in turn
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		t_reset();
		t_modes();
		t_recal();
		t_srst();
		t_bus();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [rxcal_engines.sv]
/* Model of the four receive calibration engines at the far side.
   Assumes start pulses from rxcal_control; engine i runs BASE+3*i cycles. */
`timescale 1ns/1ps
`default_nettype none
module rxcal_engines
	import rxcal_pkg::*;
#(
	parameter int BASE = 4
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_b_i,
	input  wire logic [CAL_COUNT-1:0] start_i,
	output logic      [CAL_COUNT-1:0] done_o
);
	logic [5:0] cnt_q [CAL_COUNT];
	// Done drops on start and rises when the engine's count runs out
	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < CAL_COUNT; i++) begin
			if (!rst_b_i) begin
				cnt_q[i] <= 6'h00;
				done_o[i] <= 1'b1;
			end else if (start_i[i]) begin
				cnt_q[i] <= 6'(BASE + 3 * i);
				done_o[i] <= 1'b0;
			end else if (cnt_q[i] != 6'h00) begin
				cnt_q[i] <= cnt_q[i] - 6'h01;
				done_o[i] <= (cnt_q[i] == 6'h01);
			end
		end
	end
endmodule
`default_nettype wire

// [rxcal_pkg.sv]
/*
 * Shared constants and types for the receive calibration and reset control
 * block: register offsets, field positions, reset values, mode encodings,
 * bus answer codes and the soft reset timing.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package rxcal_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SOFT_RESET_NS  = 100;
	localparam int SOFT_RESET_CYC =
		(SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W      = 4;

	// Number of internal receive calibrations started by a recalibration
	localparam int CAL_COUNT = 4;

	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// Register byte addresses
	localparam logic [7:0] ADDR_CAL_CTRL = 8'h08;
	localparam logic [7:0] ADDR_REF_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_CAL_STAT = 8'h10;

	// Calibration control field positions
	localparam int BIT_SOFT_RESET  = 0;
	localparam int BIT_VCO_LSB     = 1;
	localparam int BIT_VCO_MSB     = 2;
	localparam int BIT_FORCE_RECAL = 3;

	// Reference control field positions
	localparam int BIT_REF_EN = 0;

	// Status field positions
	localparam int BIT_ST_LOL       = 0;
	localparam int BIT_ST_REF_PRES  = 1;
	localparam int BIT_ST_CENTRE    = 2;
	localparam int BIT_ST_SWEEP     = 3;
	localparam int BIT_ST_CAL_BUSY  = 4;
	localparam int BIT_ST_RST_BUSY  = 5;

	// VCO calibration mode encodings
	typedef enum logic [1:0] {
		VCO_AUTO    = 2'b00,
		VCO_REFLESS = 2'b01,
		VCO_REF     = 2'b10,
		VCO_INVALID = 2'b11
	} rxcal_vco_mode_t;

	// Reset values
	localparam rxcal_vco_mode_t VCO_MODE_RST = VCO_AUTO;
	localparam logic            REF_EN_RST   = 1'b0;

	// Avalon response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Soft reset sequencer states
	typedef enum logic {
		RST_IDLE,
		RST_RUN
	} rxcal_rst_state_t;

endpackage

// [rxcal_sequencer.sv]
/*
 * Calibration sequencer: on a start pulse it launches every internal
 * receive calibration at once and tracks each until its done level is seen.
 * Assumes done levels are already synchronised and that each engine drops
 * done when it sees its start pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module rxcal_sequencer
	import rxcal_pkg::*;
(
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 start_i,
	input  wire logic [CAL_COUNT-1:0] done_i,
	output logic      [CAL_COUNT-1:0] cal_start_o,
	output logic                      busy_o
);

	logic [CAL_COUNT-1:0] pending_q;
	logic [CAL_COUNT-1:0] armed_q;
	logic [CAL_COUNT-1:0] start_q;

	// One tracker per calibration engine
	for (genvar i = 0; i < CAL_COUNT; i++) begin : g_cal
		// Start pulse, then wait until done is seen low before trusting done
		always_ff @(posedge clk_sys_i) begin
			if (!rst_b_i) begin
				pending_q[i] <= 1'b0;
				armed_q[i]   <= 1'b0;
				start_q[i]   <= 1'b0;
			end else begin
				start_q[i] <= start_i; // RL1
				if (start_i) begin
					pending_q[i] <= 1'b1; // RL1
					armed_q[i]   <= 1'b0;
				end else if (pending_q[i] && !armed_q[i]) begin
					armed_q[i] <= !done_i[i];
				end else if (pending_q[i] && done_i[i]) begin
					pending_q[i] <= 1'b0; // RL3
				end
			end
		end
	end

	assign cal_start_o = start_q;
	assign busy_o      = |pending_q; // RL3

endmodule

`default_nettype wire

// [rxcal_sync.sv]
/*
 * Two flip-flop synchroniser for a group of independent level signals.
 * Assumes each bit is a slow level from outside the system clock domain;
 * multi-bit words are not kept coherent.
 */
`timescale 1ns/1ps
`default_nettype none

module rxcal_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

`default_nettype wire
